// *** dsp_exec_pkg.sv ***
package dsp_exec_pkg;

  localparam int DATA_W = 32;
  localparam int PC_W = 24;
  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] DST_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SRC_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SRC2_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] PC_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] SP_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] TOP_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] LAST_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] PAR_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] MEM_ADDR_OFS = 8'h2c;
  localparam logic [ADDR_W-1:0] MEM_DATA_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] AUX_OFS = 8'h34;

  // Command word fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_COND_TRUE_BIT = 8;
  localparam int CMD_COND_GIVEN_BIT = 9;
  localparam int CMD_IDX_LSB = 10;
  localparam int CMD_ALT_BIT = 15;
  localparam int CMD_VEC_LSB = 16;

  // Parallel operand descriptor fields.
  localparam int PAR_SRC1_LSB = 0;
  localparam int PAR_SRC3_LSB = 5;
  localparam int PAR_DST1_LSB = 10;
  localparam int PAR_OP3_LSB = 15;
  localparam int PAR_OP6_LSB = 20;
  localparam int PAR_DISP_LSB = 25;
  localparam int PAR_KIND_LSB = 28;

  // Status bit positions.
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_NEG = 2;
  localparam int ST_GIE = 3;
  localparam int ST_LOOP = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_ILLEGAL = 6;
  localparam int ST_LOCK = 7;
  localparam int ST_EMU = 8;

  localparam logic [4:0] EXT_REG_LAST = 5'h0_7;
  localparam logic [2:0] DISP_LAST = 3'h3;

  // Command opcodes.
  localparam logic [4:0] OP_NONE = 5'h0_0;
  localparam logic [4:0] OP_INT_RET = 5'h0_1;
  localparam logic [4:0] OP_SUB_RET = 5'h0_2;
  localparam logic [4:0] OP_ROT_L = 5'h0_3;
  localparam logic [4:0] OP_ROT_R = 5'h0_4;
  localparam logic [4:0] OP_ROT_LC = 5'h0_5;
  localparam logic [4:0] OP_ROT_RC = 5'h0_6;
  localparam logic [4:0] OP_BLOCK_LOOP = 5'h0_7;
  localparam logic [4:0] OP_SINGLE_LOOP = 5'h0_8;
  localparam logic [4:0] OP_SIGNAL = 5'h0_9;
  localparam logic [4:0] OP_LOCK_STORE = 5'h0_a;
  localparam logic [4:0] OP_COND_SUB = 5'h0_b;
  localparam logic [4:0] OP_BORROW_SUB = 5'h0_c;
  localparam logic [4:0] OP_REV_SUB = 5'h0_d;
  localparam logic [4:0] OP_REV_BORROW = 5'h0_e;
  localparam logic [4:0] OP_REV_FLOAT = 5'h0_f;
  localparam logic [4:0] OP_TRAP = 5'h1_0;
  localparam logic [4:0] OP_BIT_TEST = 5'h1_1;
  localparam logic [4:0] OP_EMU_INT = 5'h1_2;
  localparam logic [4:0] OP_FLOAT_PUSH = 5'h1_3;
  localparam logic [4:0] OP_PAR_STORE = 5'h1_4;
  localparam logic [4:0] OP_PAR_MPY_ADD = 5'h1_5;

  localparam logic [PC_W-1:0] PC_RESET = 24'h00_0000;
  localparam logic [PC_W-1:0] SP_RESET = 24'h00_0000;

  typedef enum logic {IDLE, WAIT_ACK} exec_state_t;

endpackage : dsp_exec_pkg

// *** dsp_exec_properties.sv ***
module dsp_exec_properties
  import dsp_exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic interlock,
  input wire logic interlock_ack,
  input wire logic interlock_end
);
  logic acc;
  logic cmd_wr;
  assign acc = psel && penable && pready;
  assign cmd_wr = acc && pwrite && paddr == CMD_OFS;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_first_access;
    psel && penable && !$past(penable);
  endsequence
  // A locked store only pulses the end marker when no stall is pending, since busy drops commands.
  sequence s_lock_store;
    cmd_wr && pwdata[4:0] == OP_LOCK_STORE && !interlock;
  endsequence

  AST_READY_SLOT: assert property (s_first_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_MAP: assert property (acc |-> pslverr == (paddr > AUX_OFS || paddr[1:0] != 2'b00))
    else $error("pslverr does not match the address map");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_LOCK_CAUSE: assert property ($rose(interlock) |-> $past(cmd_wr && pwdata[4:0] == OP_SIGNAL))
    else $error("interlock rose without a signal command");
  AST_LOCK_STALL: assert property (interlock && !interlock_ack && !cmd_wr |=> interlock)
    else $error("interlock dropped before acknowledge");
  AST_LOCK_RELEASE: assert property (interlock && interlock_ack |=> !interlock)
    else $error("interlock held after acknowledge");
  AST_END_AFTER_STORE: assert property (s_lock_store |=> interlock_end ##1 !interlock_end)
    else $error("end marker not a single pulse after locked store");
  AST_END_CAUSE: assert property (interlock_end |-> $past(cmd_wr && pwdata[4:0] == OP_LOCK_STORE))
    else $error("end marker without locked store");
endmodule : dsp_exec_properties

bind dsp_instruction_semantics dsp_exec_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .interlock(interlock),
  .interlock_ack(interlock_ack), .interlock_end(interlock_end));

// *** dsp_instruction_semantics.sv ***
// Added by the designer: the placing of the registers and the APB interface to the registers.
module dsp_instruction_semantics
  import dsp_exec_pkg::*;
#(
  parameter int MEM_DEPTH = 16,
  parameter logic [PC_W-1:0] EMU_VECTOR = 24'h00_0001
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic interlock,
  input wire logic interlock_ack,
  output logic interlock_end
);

  localparam int MA_W = $clog2(MEM_DEPTH);

  typedef struct packed {
    exec_state_t state;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] src2;
    logic [DATA_W-1:0] aux;
    logic [DATA_W-1:0] par;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] sp;
    logic [PC_W-1:0] loop_top_word;
    logic [PC_W-1:0] loop_last_word;
    logic [DATA_W-1:0] loop_count_left;
    logic carry;
    logic zero;
    logic neg;
    logic global_int_enable;
    logic loop_active_flag;
    logic illegal;
    logic emu;
    logic lock;
    logic lock_end;
    logic [MA_W-1:0] mem_addr;
    logic [MEM_DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic access;
  logic wr_en;
  logic rd_en;
  logic [4:0] op;
  logic take;
  logic alt;
  logic [4:0] idx;
  logic [4:0] vec;
  logic [PC_W-1:0] next_pc;
  logic [MA_W-1:0] sp_ix;
  logic [MA_W-1:0] sp_up_ix;
  logic [MA_W-1:0] st_ix;
  logic [DATA_W:0] wide;
  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] result;
  logic set_flags;
  logic write_dst;
  logic par_regs_ok;
  logic par_disp_ok;
  logic mpy_ok;
  logic [2:0] kind_sum;
  logic [DATA_W-1:0] status_word;
  logic mapped;
  logic [DATA_W-1:0] rd_mux;

  assign access = psel & penable;
  assign wr_en = access & st_r.ready & pwrite;
  assign rd_en = access & ~st_r.ready & ~pwrite;
  assign op = pwdata[CMD_OP_LSB +: 5];
  assign alt = pwdata[CMD_ALT_BIT];
  assign idx = pwdata[CMD_IDX_LSB +: 5];
  assign vec = pwdata[CMD_VEC_LSB +: 5];
  // An omitted condition counts as true.
  assign take = ~pwdata[CMD_COND_GIVEN_BIT] | pwdata[CMD_COND_TRUE_BIT];
  assign next_pc = st_r.pc + 24'h00_0001;
  assign sp_ix = st_r.sp[MA_W-1:0];
  assign sp_up_ix = MA_W'(st_r.sp + 24'h00_0001);
  assign st_ix = st_r.src2[MA_W-1:0];

  // Operand legality of the parallel forms, from the descriptor register.
  assign par_regs_ok = (st_r.par[PAR_SRC1_LSB +: 5] <= EXT_REG_LAST)
                     && (st_r.par[PAR_SRC3_LSB +: 5] <= EXT_REG_LAST)
                     && (st_r.par[PAR_DST1_LSB +: 5] <= EXT_REG_LAST);
  assign par_disp_ok = st_r.par[PAR_DISP_LSB +: 3] <= DISP_LAST;
  assign kind_sum = 3'(st_r.par[PAR_KIND_LSB]) + 3'(st_r.par[PAR_KIND_LSB+1])
                  + 3'(st_r.par[PAR_KIND_LSB+2]) + 3'(st_r.par[PAR_KIND_LSB+3]);
  assign mpy_ok = (st_r.par[PAR_OP3_LSB +: 5] <= 5'h0_1)
                && (st_r.par[PAR_OP6_LSB +: 5] >= 5'h0_2)
                && (st_r.par[PAR_OP6_LSB +: 5] <= 5'h0_3)
                && (kind_sum == 3'h2) && par_disp_ok;

  always_comb begin
    status_word = '0;
    status_word[ST_CARRY] = st_r.carry;
    status_word[ST_ZERO] = st_r.zero;
    status_word[ST_NEG] = st_r.neg;
    status_word[ST_GIE] = st_r.global_int_enable;
    status_word[ST_LOOP] = st_r.loop_active_flag;
    status_word[ST_BUSY] = st_r.state == WAIT_ACK;
    status_word[ST_ILLEGAL] = st_r.illegal;
    status_word[ST_LOCK] = st_r.lock;
    status_word[ST_EMU] = st_r.emu;
  end

  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      CMD_OFS: rd_mux = '0;
      DST_OFS: rd_mux = st_r.dst;
      SRC_OFS: rd_mux = st_r.src;
      SRC2_OFS: rd_mux = st_r.src2;
      STATUS_OFS: rd_mux = status_word;
      PC_OFS: rd_mux = DATA_W'(st_r.pc);
      SP_OFS: rd_mux = DATA_W'(st_r.sp);
      TOP_OFS: rd_mux = DATA_W'(st_r.loop_top_word);
      LAST_OFS: rd_mux = DATA_W'(st_r.loop_last_word);
      COUNT_OFS: rd_mux = st_r.loop_count_left;
      PAR_OFS: rd_mux = st_r.par;
      MEM_ADDR_OFS: rd_mux = DATA_W'(st_r.mem_addr);
      MEM_DATA_OFS: rd_mux = st_r.mem[st_r.mem_addr];
      AUX_OFS: rd_mux = st_r.aux;
      default: mapped = 1'b0;
    endcase
  end

  // Arithmetic of the single-word operations, all read from current state.
  always_comb begin
    wide = '0;
    diff = st_r.dst - st_r.src;
    result = st_r.dst;
    set_flags = 1'b0;
    write_dst = 1'b0;
    unique case (op)
      OP_ROT_L: begin
        result = {st_r.dst[DATA_W-2:0], st_r.dst[DATA_W-1]};
        write_dst = 1'b1;
        set_flags = 1'b1;
      end
      OP_ROT_R: begin
        result = {st_r.dst[0], st_r.dst[DATA_W-1:1]};
        write_dst = 1'b1;
        set_flags = 1'b1;
      end
      OP_ROT_LC: begin
        wide = {st_r.dst, st_r.carry};
        result = wide[DATA_W-1:0];
        write_dst = 1'b1;
        set_flags = 1'b1;
      end
      OP_ROT_RC: begin
        wide = {st_r.carry, st_r.dst};
        result = wide[DATA_W:1];
        write_dst = 1'b1;
        set_flags = 1'b1;
      end
      OP_COND_SUB: begin
        if (!diff[DATA_W-1]) begin
          result = {diff[DATA_W-2:0], 1'b1};
        end else begin
          result = {st_r.dst[DATA_W-2:0], 1'b0};
        end
        write_dst = 1'b1;
      end
      OP_BORROW_SUB: begin
        if (alt) begin
          wide = {1'b0, st_r.src} - {1'b0, st_r.src2} - (DATA_W+1)'(st_r.carry);
        end else begin
          wide = {1'b0, st_r.dst} - {1'b0, st_r.src} - (DATA_W+1)'(st_r.carry);
        end
        result = wide[DATA_W-1:0];
        write_dst = 1'b1;
        set_flags = 1'b1;
      end
      OP_REV_SUB, OP_REV_FLOAT: begin
        wide = {1'b0, st_r.src} - {1'b0, st_r.dst};
        result = wide[DATA_W-1:0];
        write_dst = (op == OP_REV_SUB) || (idx <= EXT_REG_LAST);
        set_flags = write_dst;
      end
      OP_REV_BORROW: begin
        wide = {1'b0, st_r.src} - {1'b0, st_r.dst} - (DATA_W+1)'(st_r.carry);
        result = wide[DATA_W-1:0];
        write_dst = 1'b1;
        set_flags = 1'b1;
      end
      OP_BIT_TEST: begin
        result = alt ? (st_r.src & st_r.src2) : (st_r.dst & st_r.src);
        set_flags = 1'b1;
      end
      default: result = st_r.dst;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.lock_end = 1'b0;
    // One wait cycle in every access keeps prdata a pure flip-flop output.
    st_nxt.ready = access & ~st_r.ready;
    if (rd_en) begin
      st_nxt.rdata = rd_mux;
    end
    // The error flag is a one-cycle answer that stands beside pready only.
    st_nxt.slverr = access & ~st_r.ready & ~mapped;
    if (st_r.state == WAIT_ACK && interlock_ack) begin
      st_nxt.lock = 1'b0;
      st_nxt.state = IDLE;
    end
    if (wr_en && mapped) begin
      unique case (paddr)
        DST_OFS: st_nxt.dst = pwdata;
        SRC_OFS: st_nxt.src = pwdata;
        SRC2_OFS: st_nxt.src2 = pwdata;
        STATUS_OFS: begin
          st_nxt.carry = pwdata[ST_CARRY];
          st_nxt.global_int_enable = pwdata[ST_GIE];
          st_nxt.loop_active_flag = pwdata[ST_LOOP];
          st_nxt.illegal = st_r.illegal & ~pwdata[ST_ILLEGAL];
          st_nxt.emu = st_r.emu & ~pwdata[ST_EMU];
        end
        PC_OFS: st_nxt.pc = pwdata[PC_W-1:0];
        SP_OFS: st_nxt.sp = pwdata[PC_W-1:0];
        TOP_OFS: st_nxt.loop_top_word = pwdata[PC_W-1:0];
        LAST_OFS: st_nxt.loop_last_word = pwdata[PC_W-1:0];
        COUNT_OFS: st_nxt.loop_count_left = pwdata;
        PAR_OFS: st_nxt.par = pwdata;
        MEM_ADDR_OFS: st_nxt.mem_addr = pwdata[MA_W-1:0];
        MEM_DATA_OFS: st_nxt.mem[st_r.mem_addr] = pwdata;
        AUX_OFS: st_nxt.aux = pwdata;
        CMD_OFS: begin
          // Commands are dropped while an interlock wait is open.
          if (st_r.state == IDLE) begin
            st_nxt.pc = next_pc;
            if (write_dst) begin
              st_nxt.dst = result;
            end
            if (set_flags) begin
              st_nxt.zero = result == '0;
              st_nxt.neg = result[DATA_W-1];
              if (op == OP_ROT_LC) begin
                st_nxt.carry = st_r.dst[DATA_W-1];
              end else if (op == OP_ROT_RC) begin
                st_nxt.carry = st_r.dst[0];
              end else if (op != OP_BIT_TEST) begin
                st_nxt.carry = wide[DATA_W];
              end
            end
            unique case (op)
              OP_REV_FLOAT: if (idx > EXT_REG_LAST) begin
                st_nxt.illegal = 1'b1;
              end
              OP_INT_RET: if (take) begin
                st_nxt.pc = st_r.mem[sp_ix][PC_W-1:0];
                st_nxt.global_int_enable = 1'b1;
              end
              OP_SUB_RET: if (take) begin
                st_nxt.pc = st_r.mem[sp_ix][PC_W-1:0];
                st_nxt.sp = st_r.sp - 24'h00_0001;
              end
              OP_BLOCK_LOOP: begin
                st_nxt.loop_last_word = st_r.src[PC_W-1:0];
                st_nxt.loop_active_flag = 1'b1;
                st_nxt.loop_top_word = next_pc;
              end
              OP_SINGLE_LOOP: begin
                st_nxt.loop_count_left = st_r.src;
                st_nxt.loop_active_flag = 1'b1;
                st_nxt.loop_top_word = next_pc;
                st_nxt.loop_last_word = next_pc;
              end
              OP_SIGNAL: begin
                st_nxt.lock = 1'b1;
                st_nxt.state = WAIT_ACK;
              end
              OP_LOCK_STORE: begin
                st_nxt.mem[st_ix] = st_r.src;
                st_nxt.lock = 1'b0;
                st_nxt.lock_end = 1'b1;
              end
              OP_TRAP: if (take) begin
                st_nxt.sp = st_r.sp + 24'h00_0001;
                st_nxt.mem[sp_up_ix] = DATA_W'(next_pc);
                st_nxt.pc = st_r.mem[MA_W'(vec)][PC_W-1:0];
                st_nxt.global_int_enable = 1'b0;
              end
              OP_EMU_INT: begin
                // The emulator sequence leaves stack and interrupt enable untouched.
                st_nxt.emu = 1'b1;
                st_nxt.pc = EMU_VECTOR;
              end
              OP_FLOAT_PUSH: begin
                st_nxt.sp = st_r.sp + 24'h00_0001;
                st_nxt.mem[sp_up_ix] = st_r.dst;
              end
              OP_PAR_STORE: begin
                if (par_regs_ok && par_disp_ok) begin
                  // Old dst is stored while the new dst is loaded: reads precede writes.
                  st_nxt.dst = st_r.src + st_r.src2;
                  st_nxt.mem[st_ix] = st_r.dst;
                end else begin
                  st_nxt.illegal = 1'b1;
                end
              end
              OP_PAR_MPY_ADD: begin
                if (mpy_ok) begin
                  st_nxt.dst = st_r.src * st_r.src2;
                  if (alt) begin
                    st_nxt.aux = st_r.dst - st_r.aux;
                  end else begin
                    st_nxt.aux = st_r.dst + st_r.aux;
                  end
                end else begin
                  st_nxt.illegal = 1'b1;
                end
              end
              default: st_nxt.illegal = st_r.illegal;
            endcase
          end
        end
        default: st_nxt.slverr = st_r.slverr;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.state <= IDLE;
      st_r.pc <= PC_RESET;
      st_r.sp <= SP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slverr;
  assign interlock = st_r.lock;
  assign interlock_end = st_r.lock_end;

endmodule : dsp_instruction_semantics

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dsp_exec_pkg::*;
  localparam logic [PC_W-1:0] EMU_AT = 24'h00_0020;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic interlock_ack = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, interlock, interlock_end, c, err;
  logic [31:0] rd, d, s, v, e;
  logic [31:0] pt [8];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int end_cnt = 0;
  int k0;

  dsp_instruction_semantics #(.MEM_DEPTH(16), .EMU_VECTOR(EMU_AT)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interlock(interlock), .interlock_ack(interlock_ack), .interlock_end(interlock_end));

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // The whole sequence needs under 2000 cycles; the ceiling leaves wide margin for slow answers.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (interlock_end === 1'b1) end_cnt <= end_cnt + 1;
    if (cyc == 8000) begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask : wr

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, rd, exp);
  endtask : rchk

  task automatic st_chk(input string n, input int b, input logic exp);
    xfer(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(n, {31'h0, rd[b]}, {31'h0, exp});
  endtask : st_chk

  function automatic logic [31:0] cw(input logic [4:0] op, input logic [4:0] vec,
                                     input logic [1:0] cond);
    cw = {11'h0, vec, 6'h0, cond, 3'h0, op};
  endfunction : cw

  function automatic logic [31:0] pd(input logic [4:0] s1, input logic [4:0] s3,
    input logic [4:0] d1, input logic [4:0] o3, input logic [4:0] o6, input logic [2:0] dp,
    input logic [3:0] kind);
    pd = {kind, dp, o6, o3, d1, s3, s1};
  endfunction : pd

  initial begin
    void'($urandom(908));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status", STATUS_OFS, 32'h0000_0000);
    rchk("pc", PC_OFS, 32'h0000_0000);
    rchk("sp", SP_OFS, 32'h0000_0000);
    xfer(1'b0, 8'h38, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    wr(PC_OFS, 32'hffff_ffff);
    rchk("pc", PC_OFS, 32'h00ff_ffff);
    for (int k = 0; k < 16; k++) begin
      d = (k < 4) ? $urandom : $urandom & 32'h0000_ffff;
      s = (k < 8) ? d : $urandom & 32'h0000_ffff;
      c = 1'($urandom);
      wr(STATUS_OFS, {31'h0, c});
      wr(DST_OFS, d);
      wr(SRC_OFS, s);
      wr(CMD_OFS, cw((k < 4) ? OP_ROT_L + 5'(k) : OP_COND_SUB + 5'(k % 4), 5'h0, 2'b00));
      case (k)
        0: e = {d[30:0], d[31]};
        1: e = {d[0], d[31:1]};
        2: e = {d[30:0], c};
        3: e = {c, d[31:1]};
        default: e = (k % 4 == 0) ? ((d >= s) ? (((d - s) << 1) | 1) : (d << 1)) :
                     (k % 4 == 1) ? d - s - c : (k % 4 == 2) ? s - d : s - d - c;
      endcase
      rchk("dst", DST_OFS, e);
      if (k == 2 || k == 3) st_chk("carry", ST_CARRY, (k == 2) ? d[31] : d[0]);
    end
    wr(STATUS_OFS, 32'h0000_0040);
    wr(CMD_OFS, cw(OP_REV_FLOAT, 5'h0, 2'b00) | 32'h0000_2000);
    rchk("dst", DST_OFS, e);
    st_chk("illegal", ST_ILLEGAL, 1'b1);
    for (int k = 0; k < 2; k++) begin
      d = $urandom | 32'h0000_0001;
      wr(DST_OFS, d);
      wr(SRC_OFS, k ? d : ~d);
      wr(CMD_OFS, cw(OP_BIT_TEST, 5'h0, 2'b00));
      rchk("dst", DST_OFS, d);
      st_chk("zero", ST_ZERO, k == 0);
    end
    for (int k = 0; k < 2; k++) begin
      wr(STATUS_OFS, 32'h0000_0000);
      wr(PC_OFS, 32'h100 * (k + 1));
      s = $urandom & 32'h00ff_ffff;
      wr(SRC_OFS, s);
      wr(CMD_OFS, cw(k ? OP_SINGLE_LOOP : OP_BLOCK_LOOP, 5'h0, 2'b00));
      rchk("top", TOP_OFS, 32'h100 * (k + 1) + 1);
      rchk("last", LAST_OFS, k ? 32'h201 : s);
      if (k) rchk("count", COUNT_OFS, s);
      st_chk("loop", ST_LOOP, 1'b1);
    end
    wr(MEM_ADDR_OFS, 32'h5);
    wr(MEM_DATA_OFS, 32'h0000_0abc);
    wr(SP_OFS, 32'h3);
    wr(PC_OFS, 32'h40);
    wr(STATUS_OFS, 32'h0000_0008);
    wr(CMD_OFS, cw(OP_TRAP, 5'h5, 2'b11));
    rchk("pc", PC_OFS, 32'h0000_0abc);
    rchk("sp", SP_OFS, 32'h4);
    st_chk("gie", ST_GIE, 1'b0);
    wr(MEM_ADDR_OFS, 32'h4);
    rchk("stack", MEM_DATA_OFS, 32'h41);
    wr(CMD_OFS, cw(OP_TRAP, 5'h5, 2'b10));
    rchk("pc", PC_OFS, 32'h0000_0abd);
    wr(CMD_OFS, cw(OP_INT_RET, 5'h0, 2'b00));
    rchk("pc", PC_OFS, 32'h41);
    st_chk("gie", ST_GIE, 1'b1);
    wr(CMD_OFS, cw(OP_SUB_RET, 5'h0, 2'b10));
    rchk("pc", PC_OFS, 32'h42);
    wr(PC_OFS, 32'h77);
    wr(CMD_OFS, cw(OP_SUB_RET, 5'h0, 2'b11));
    rchk("pc", PC_OFS, 32'h41);
    rchk("sp", SP_OFS, 32'h3);
    wr(CMD_OFS, cw(OP_FLOAT_PUSH, 5'h0, 2'b00));
    rchk("sp", SP_OFS, 32'h4);
    rchk("push", MEM_DATA_OFS, d);
    wr(CMD_OFS, cw(OP_EMU_INT, 5'h0, 2'b00));
    rchk("pc", PC_OFS, 32'(EMU_AT));
    st_chk("emu", ST_EMU, 1'b1);
    d = $urandom;
    wr(DST_OFS, d);
    wr(CMD_OFS, cw(OP_SIGNAL, 5'h0, 2'b00));
    #1 chk("lock", {31'h0, interlock}, 32'h1);
    wr(CMD_OFS, cw(OP_ROT_L, 5'h0, 2'b00));
    st_chk("busy", ST_BUSY, 1'b1);
    chk("lock", {31'h0, interlock}, 32'h1);
    interlock_ack <= 1'b1;
    @(posedge pclk);
    interlock_ack <= 1'b0;
    #1 chk("lock", {31'h0, interlock}, 32'h0);
    rchk("dst", DST_OFS, d);
    v = $urandom;
    wr(SRC_OFS, v);
    wr(SRC2_OFS, 32'h6);
    k0 = end_cnt;
    wr(CMD_OFS, cw(OP_LOCK_STORE, 5'h0, 2'b00));
    repeat (2) @(posedge pclk);
    chk("end", 32'(end_cnt - k0), 32'h1);
    wr(MEM_ADDR_OFS, 32'h6);
    rchk("stored", MEM_DATA_OFS, v);
    pt = '{pd(1, 2, 3, 0, 2, 3, 4'h3), pd(1, 2, 3, 1, 3, 0, 4'hc), pd(8, 2, 3, 0, 2, 0, 4'h3),
           pd(1, 2, 9, 0, 2, 0, 4'h3), pd(1, 2, 3, 0, 2, 4, 4'h3), pd(1, 2, 3, 2, 2, 0, 4'h3),
           pd(1, 2, 3, 0, 1, 0, 4'h3), pd(1, 2, 3, 0, 2, 0, 4'h7)};
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      s = $urandom;
      wr(STATUS_OFS, 32'h0000_0040);
      wr(PAR_OFS, pt[k]);
      wr(DST_OFS, d);
      wr(SRC_OFS, s);
      wr(SRC2_OFS, 32'h9);
      wr(CMD_OFS, cw((k == 1 || k >= 5) ? OP_PAR_MPY_ADD : OP_PAR_STORE, 5'h0, 2'b00));
      e = (k == 0) ? s + 32'h9 : (k == 1) ? s * 32'h9 : d;
      rchk("par dst", DST_OFS, e);
      st_chk("illegal", ST_ILLEGAL, k >= 2);
      wr(MEM_ADDR_OFS, 32'h9);
      if (k == 0) rchk("par mem", MEM_DATA_OFS, d);
      if (k == 1) rchk("par aux", AUX_OFS, d);
    end
    wrap_up();
  end
endmodule : tb_top
